/* timer_wave_control.sv */
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module timer_wave_control
    import timer_wave_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic pin_override_a_o,
    output logic pin_override_b_o,
    output logic overflow_flag_o,
    output logic match_flag_a_o,
    output logic match_flag_b_o
);

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [3:0] ctrl_b;
        logic [7:0] count;
        logic dir_up;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b_buf;
        logic [7:0] cmp_b;
        logic block;
        logic [2:0] flags;
        logic [7:0] rdata;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    logic tick;
    logic [2:0] mode;
    wave_kind_t kind;
    logic [7:0] top;
    logic at_top;
    logic at_bottom;
    logic at_max;
    logic ovf_set;
    logic load_cmp;
    logic dir_eff;
    logic fast_bottom;
    logic pc_top;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [1:0] match;
    logic [1:0] force_cmp;
    logic [1:0] cmp_eq_top;
    logic [1:0][1:0] out_mode;
    logic [1:0] wave;
    logic [1:0] connect;

    tick_divider #(
        .PRESC_W(10)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clk_sel_i(st_r.ctrl_b[CB_CLK_SEL_LSB +: 3]),
        .tick_o(tick)
    );

    always_comb begin
        st_nxt = st_r;
        flag_set = '0;
        flag_clr = '0;
        force_cmp = '0;
        ovf_set = 1'b0;
        load_cmp = 1'b0;

        // Three-bit mode from both control registers
        mode = {st_r.ctrl_b[CB_GEN_HI_BIT], st_r.ctrl_a[CA_GEN_LOW_LSB +: 2]}; // [RULE13] [RULE20]

        case (mode)
            MODE_PC_FULL,
            MODE_PC_CMP: kind = KIND_PC;
            MODE_FAST_FULL,
            MODE_FAST_CMP: kind = KIND_FAST;
            default: kind = KIND_NONPWM;
        endcase

        // Reserved modes 4 and 6 run as plain counting
        if (mode == MODE_CTC || mode == MODE_PC_CMP || mode == MODE_FAST_CMP) begin
            top = st_r.cmp_a; // [RULE14] [RULE15] [RULE17]
        end else begin
            top = COUNT_MAX; // [RULE14] [RULE15] [RULE17]
        end

        at_top = st_r.count == top;
        at_bottom = st_r.count == COUNT_BOTTOM; // [RULE16]
        at_max = st_r.count == COUNT_MAX; // [RULE16]
        dir_eff = st_r.dir_up | at_bottom;
        fast_bottom = tick && kind == KIND_FAST && at_top;
        pc_top = tick && kind == KIND_PC && at_top && st_r.dir_up;

        // A count write blocks the compare on the next tick
        match[0] = tick && !st_r.block && st_r.count == st_r.cmp_a;
        match[1] = tick && !st_r.block && st_r.count == st_r.cmp_b;
        cmp_eq_top[0] = st_r.cmp_a == top; // [RULE7] [RULE8]
        cmp_eq_top[1] = st_r.cmp_b == top; // [RULE8]
        out_mode[0] = st_r.ctrl_a[CA_OUT_A_LSB +: 2];
        out_mode[1] = st_r.ctrl_a[CA_OUT_B_LSB +: 2];

        if (tick) begin
            st_nxt.block = 1'b0;
            case (kind)
                KIND_PC: begin
                    if (st_r.dir_up) begin
                        if (at_top) begin
                            st_nxt.dir_up = 1'b0; // [RULE18]
                            st_nxt.count = st_r.count - 1'b1;
                        end else begin
                            st_nxt.count = st_r.count + 1'b1;
                        end
                    end else begin
                        if (at_bottom) begin
                            st_nxt.dir_up = 1'b1;
                            st_nxt.count = st_r.count + 1'b1;
                        end else begin
                            st_nxt.count = st_r.count - 1'b1;
                        end
                    end
                end
                default: begin
                    st_nxt.dir_up = 1'b1;
                    if (at_top) begin
                        st_nxt.count = COUNT_BOTTOM; // [RULE19]
                    end else begin
                        st_nxt.count = st_r.count + 1'b1;
                    end
                end
            endcase

            case (mode)
                MODE_PC_FULL,
                MODE_PC_CMP: begin
                    ovf_set = at_bottom; // [RULE15]
                    load_cmp = at_top && st_r.dir_up; // [RULE15] [RULE21]
                end
                MODE_FAST_FULL: begin
                    ovf_set = at_max; // [RULE15]
                    load_cmp = at_top; // [RULE15]
                end
                MODE_FAST_CMP: begin
                    ovf_set = at_top; // [RULE15]
                    load_cmp = at_top; // [RULE15]
                end
                default: begin
                    ovf_set = at_max; // [RULE14]
                end
            endcase
        end

        // Double buffered modes take the new compare values at their update point
        if (kind == KIND_NONPWM) begin
            st_nxt.cmp_a = st_r.cmp_a_buf; // [RULE14]
            st_nxt.cmp_b = st_r.cmp_b_buf; // [RULE14]
        end else if (load_cmp) begin
            st_nxt.cmp_a = st_r.cmp_a_buf;
            st_nxt.cmp_b = st_r.cmp_b_buf;
        end

        flag_set[FL_OVF_BIT] = ovf_set;
        flag_set[FL_MATCH_A_BIT] = match[0];
        flag_set[FL_MATCH_B_BIT] = match[1];

        if (wr_i) begin
            if (addr_i == OFS_CTRL_A) begin
                st_nxt.ctrl_a = wdata_i & CTRL_A_WMASK; // [RULE12] [RULE22]
            end else if (addr_i == OFS_CTRL_B) begin
                st_nxt.ctrl_b = wdata_i[3:0] & CTRL_B_WMASK;
                if (kind == KIND_NONPWM) begin
                    force_cmp[0] = wdata_i[CB_FORCE_A_BIT];
                    force_cmp[1] = wdata_i[CB_FORCE_B_BIT];
                end
            end else if (addr_i == OFS_COUNT) begin
                st_nxt.count = wdata_i;
                st_nxt.block = 1'b1;
            end else if (addr_i == OFS_CMP_A) begin
                st_nxt.cmp_a_buf = wdata_i;
                if (kind == KIND_NONPWM) begin
                    st_nxt.cmp_a = wdata_i; // [RULE14]
                end
            end else if (addr_i == OFS_CMP_B) begin
                st_nxt.cmp_b_buf = wdata_i;
                if (kind == KIND_NONPWM) begin
                    st_nxt.cmp_b = wdata_i; // [RULE14]
                end
            end else if (addr_i == OFS_FLAGS) begin
                flag_clr = wdata_i[2:0];
            end
        end

        // A flag raised in the cycle it is cleared stays set
        st_nxt.flags = (st_r.flags & ~flag_clr) | flag_set;

        st_nxt.rdata = 8'h00;
        if (rd_i) begin
            if (addr_i == OFS_CTRL_A) begin
                st_nxt.rdata = st_r.ctrl_a & CTRL_A_WMASK; // [RULE12]
            end else if (addr_i == OFS_CTRL_B) begin
                st_nxt.rdata = {4'h0, st_r.ctrl_b};
            end else if (addr_i == OFS_COUNT) begin
                st_nxt.rdata = st_r.count;
            end else if (addr_i == OFS_CMP_A) begin
                st_nxt.rdata = st_r.cmp_a_buf;
            end else if (addr_i == OFS_CMP_B) begin
                st_nxt.rdata = st_r.cmp_b_buf;
            end else if (addr_i == OFS_FLAGS) begin
                st_nxt.rdata = {5'h00, st_r.flags};
            end
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_chan
        wave_channel #(
            .TOGGLE_IN_PWM(g == 0)
        ) u_chan (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .kind_i(kind),
            .out_mode_i(out_mode[g]),
            .gen_hi_i(st_r.ctrl_b[CB_GEN_HI_BIT]),
            .match_i(match[g]),
            .force_i(force_cmp[g]),
            .cmp_eq_top_i(cmp_eq_top[g]),
            .fast_bottom_i(fast_bottom),
            .pc_top_i(pc_top),
            .dir_up_i(dir_eff),
            .wave_o(wave[g]),
            .connect_o(connect[g])
        );
    end

    assign rdata_o = st_r.rdata;
    assign wave_out_a_o = wave[0];
    assign wave_out_b_o = wave[1];
    // Pin still needs its direction bit set outside to drive [RULE2]
    assign pin_override_a_o = connect[0]; // [RULE1]
    assign pin_override_b_o = connect[1]; // [RULE1]
    assign overflow_flag_o = st_r.flags[FL_OVF_BIT];
    assign match_flag_a_o = st_r.flags[FL_MATCH_A_BIT];
    assign match_flag_b_o = st_r.flags[FL_MATCH_B_BIT];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r.ctrl_a <= CTRL_A_RST;
            st_r.ctrl_b <= CTRL_B_RST;
            st_r.count <= COUNT_RST;
            st_r.dir_up <= 1'b1;
            st_r.cmp_a_buf <= CMP_RST;
            st_r.cmp_a <= CMP_RST;
            st_r.cmp_b_buf <= CMP_RST;
            st_r.cmp_b <= CMP_RST;
            st_r.block <= 1'b0;
            st_r.flags <= FLAGS_RST;
            st_r.rdata <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule : timer_wave_control

/* timer_wave_pkg.sv */
// Operation
// (RULE1) Nonzero output mode field routes the channel waveform onto its pin.
// (RULE2) Software sets the pin direction to output; override alone drives nothing.
// (RULE3) Channel A non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match.
// (RULE4) Channel A fast PWM: 2 clear on match/set at bottom, 3 inverse.
// (RULE5) Channel A PWM mode 1: disconnected when high mode bit 0, toggles when 1.
// (RULE6) Channel A phase correct: 2 clears counting up, sets counting down; 3 inverse.
// (RULE7) Channel A fast PWM with compare equal top: ignore match, act at bottom.
// (RULE8) Phase correct with compare equal top: ignore match, act at top.
// (RULE9) Channel B non-PWM: 0 off, 1 toggle, 2 clear, 3 set on match.
// (RULE10) Channel B fast PWM: 1 reserved, 2 clear/set bottom, 3 inverse.
// (RULE11) Channel B phase correct: 1 reserved, 2 clear up/set down, 3 inverse.
// (RULE12) Control register A bits 3 and 2 always read zero.
// (RULE13) Mode is high bit from control B plus two low bits; 4, 6 reserved.
// (RULE14) Mode 0 top 0xFF, mode 2 top compare A; immediate update; overflow at MAX.
// (RULE15) Modes 1, 3, 7 top, update point and overflow point as tabulated.
// (RULE16) MAX is 0xFF and BOTTOM is 0x00 in every mode.
// (RULE17) Phase correct mode 5 uses compare A as top, mode 1 uses 0xFF.
// (RULE18) Phase correct counts up to top, holds it one tick, then counts down; the code steps from top to top minus one on the next tick, with no hold.
// (RULE19) Fast PWM counts up to top, then clears on the next tick.
// (RULE20) High waveform mode bit sits at bit 3 of control register B.
// (RULE21) Mode 5 latches new compare values at top.
// (RULE22) Writes to unused control bits are ignored, they keep reading zero.
package timer_wave_pkg;

    localparam logic [7:0] OFS_CTRL_A = 8'h24;
    localparam logic [7:0] OFS_CTRL_B = 8'h25;
    localparam logic [7:0] OFS_COUNT = 8'h26;
    localparam logic [7:0] OFS_CMP_A = 8'h27;
    localparam logic [7:0] OFS_CMP_B = 8'h28;
    localparam logic [7:0] OFS_FLAGS = 8'h35;

    localparam int CA_OUT_A_LSB = 6;
    localparam int CA_OUT_B_LSB = 4;
    localparam int CA_GEN_LOW_LSB = 0;
    localparam int CB_FORCE_A_BIT = 7;
    localparam int CB_FORCE_B_BIT = 6;
    localparam int CB_GEN_HI_BIT = 3;
    localparam int CB_CLK_SEL_LSB = 0;
    localparam int FL_OVF_BIT = 0;
    localparam int FL_MATCH_A_BIT = 1;
    localparam int FL_MATCH_B_BIT = 2;

    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam logic [3:0] CTRL_B_WMASK = 4'hf;
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [3:0] CTRL_B_RST = 4'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;

    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PC_FULL = 3'h1;
    localparam logic [2:0] MODE_CTC = 3'h2;
    localparam logic [2:0] MODE_FAST_FULL = 3'h3;
    localparam logic [2:0] MODE_PC_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;

    localparam logic [2:0] SEL_STOP = 3'h0;
    localparam logic [2:0] SEL_DIV_1 = 3'h1;
    localparam logic [2:0] SEL_DIV_8 = 3'h2;
    localparam logic [2:0] SEL_DIV_64 = 3'h3;
    localparam logic [2:0] SEL_DIV_256 = 3'h4;
    localparam logic [2:0] SEL_DIV_1024 = 3'h5;
    localparam int PRESC_DIV_8 = 8;
    localparam int PRESC_DIV_64 = 64;
    localparam int PRESC_DIV_256 = 256;
    localparam int PRESC_DIV_1024 = 1024;

    typedef enum logic [1:0] {
        KIND_NONPWM,
        KIND_FAST,
        KIND_PC
    } wave_kind_t;

endpackage : timer_wave_pkg

/* tick_divider.sv */
`timescale 1ns/10ps
module tick_divider
    import timer_wave_pkg::*;
#(
    parameter int PRESC_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] clk_sel_i,
    output logic tick_o
);

    typedef struct packed {
        logic [PRESC_W-1:0] presc;
    } div_state_t;

    div_state_t div_r;
    div_state_t div_nxt;

    function automatic logic at_end(input logic [PRESC_W-1:0] cnt, input int ratio);
        logic [PRESC_W-1:0] last;
        last = PRESC_W'(ratio - 1);
        return (cnt & last) == last;
    endfunction : at_end

    always_comb begin
        div_nxt = div_r;
        div_nxt.presc = div_r.presc + 1'b1;
        case (clk_sel_i)
            SEL_DIV_1: tick_o = 1'b1;
            SEL_DIV_8: tick_o = at_end(div_r.presc, PRESC_DIV_8);
            SEL_DIV_64: tick_o = at_end(div_r.presc, PRESC_DIV_64);
            SEL_DIV_256: tick_o = at_end(div_r.presc, PRESC_DIV_256);
            SEL_DIV_1024: tick_o = at_end(div_r.presc, PRESC_DIV_1024);
            default: tick_o = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

endmodule : tick_divider

/* wave_channel.sv */
`timescale 1ns/10ps
module wave_channel
    import timer_wave_pkg::*;
#(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire wave_kind_t kind_i,
    input wire logic [1:0] out_mode_i,
    input wire logic gen_hi_i,
    input wire logic match_i,
    input wire logic force_i,
    input wire logic cmp_eq_top_i,
    input wire logic fast_bottom_i,
    input wire logic pc_top_i,
    input wire logic dir_up_i,
    output logic wave_o,
    output logic connect_o
);

    typedef struct packed {
        logic wave;
    } chan_state_t;

    chan_state_t ch_r;
    chan_state_t ch_nxt;
    logic pwm_toggle;

    always_comb begin
        ch_nxt = ch_r;
        pwm_toggle = TOGGLE_IN_PWM && gen_hi_i && out_mode_i == 2'h1; // [RULE5] [RULE10] [RULE11]
        if (out_mode_i == 2'h0) begin
            connect_o = 1'b0;
        end else if (kind_i != KIND_NONPWM && out_mode_i == 2'h1) begin
            connect_o = pwm_toggle; // [RULE5]
        end else begin
            connect_o = 1'b1; // [RULE1]
        end
        case (kind_i)
            KIND_NONPWM: begin
                if (match_i || force_i) begin // [RULE3] [RULE9]
                    case (out_mode_i)
                        2'h1: ch_nxt.wave = ~ch_r.wave;
                        2'h2: ch_nxt.wave = 1'b0;
                        2'h3: ch_nxt.wave = 1'b1;
                        default: ch_nxt.wave = ch_r.wave;
                    endcase
                end
            end
            KIND_FAST: begin
                if (pwm_toggle && match_i) begin
                    ch_nxt.wave = ~ch_r.wave; // [RULE5]
                end else if (out_mode_i[1]) begin
                    if (match_i && !cmp_eq_top_i) begin
                        ch_nxt.wave = out_mode_i[0]; // [RULE4] [RULE7] [RULE10]
                    end
                    if (fast_bottom_i) begin
                        ch_nxt.wave = ~out_mode_i[0]; // [RULE4] [RULE10]
                    end
                end
            end
            default: begin
                if (pwm_toggle && match_i) begin
                    ch_nxt.wave = ~ch_r.wave; // [RULE5]
                end else if (out_mode_i[1]) begin
                    if (cmp_eq_top_i) begin
                        if (pc_top_i) begin
                            ch_nxt.wave = ~out_mode_i[0]; // [RULE8]
                        end
                    end else if (match_i) begin
                        ch_nxt.wave = dir_up_i ? out_mode_i[0] : ~out_mode_i[0]; // [RULE6] [RULE11]
                    end
                end
            end
        endcase
    end

    assign wave_o = ch_r.wave;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ch_r <= '0;
        end else begin
            ch_r <= ch_nxt;
        end
    end

endmodule : wave_channel

/* timer_wave_control_sva.sv */
`timescale 1ns/10ps
module timer_wave_control_sva
    import timer_wave_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic wave_out_a_o,
    input wire logic wave_out_b_o,
    input wire logic pin_override_a_o,
    input wire logic pin_override_b_o,
    input wire logic overflow_flag_o,
    input wire logic match_flag_a_o,
    input wire logic match_flag_b_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_rdata_idle;
        !rd_i |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    property p_route_a;
        wr_i && addr_i == OFS_CTRL_A |=> pin_override_a_o == (|$past(wdata_i[7:6]));
    endproperty
    a_route_a: assert property (p_route_a)
        else $error("channel a pin routing wrong");

    property p_route_b;
        wr_i && addr_i == OFS_CTRL_A |=> pin_override_b_o == (|$past(wdata_i[5:4]));
    endproperty
    a_route_b: assert property (p_route_b)
        else $error("channel b pin routing wrong");

    property p_ctrl_a_readback;
        wr_i && addr_i == OFS_CTRL_A ##1 rd_i && addr_i == OFS_CTRL_A
            |=> rdata_o == ($past(wdata_i, 2) & 8'hf3);
    endproperty
    a_ctrl_a_readback: assert property (p_ctrl_a_readback)
        else $error("control a readback wrong");

    property p_ctrl_b_readback;
        wr_i && addr_i == OFS_CTRL_B ##1 rd_i && addr_i == OFS_CTRL_B
            |=> rdata_o == {4'h0, $past(wdata_i[3:0], 2)};
    endproperty
    a_ctrl_b_readback: assert property (p_ctrl_b_readback)
        else $error("control b readback wrong");

    property p_ovf_sticky;
        overflow_flag_o && !(wr_i && addr_i == OFS_FLAGS && wdata_i[FL_OVF_BIT])
            |=> overflow_flag_o;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped without clear");

    property p_match_a_clear;
        $fell(match_flag_a_o) |-> $past(wr_i && addr_i == OFS_FLAGS && wdata_i[FL_MATCH_A_BIT]);
    endproperty
    a_match_a_clear: assert property (p_match_a_clear)
        else $error("match flag a dropped without clear");

    property p_flags_read;
        rd_i && addr_i == OFS_FLAGS |=> rdata_o ==
            {5'h00, $past(match_flag_b_o), $past(match_flag_a_o), $past(overflow_flag_o)};
    endproperty
    a_flags_read: assert property (p_flags_read)
        else $error("flag read wrong");

    property p_wave_a_idle;
        !pin_override_a_o && $past(!pin_override_a_o) |-> $stable(wave_out_a_o);
    endproperty
    a_wave_a_idle: assert property (p_wave_a_idle)
        else $error("disconnected channel a output moved");
endmodule : timer_wave_control_sva

/* testbench.sv */
`timescale 1ns/10ps
module testbench
    import timer_wave_pkg::*;
;
    typedef struct packed {
        logic [7:0] ca;
        logic [7:0] cb;
        logic [7:0] cmpa;
        logic [7:0] cmpb;
        logic [15:0] n;
        logic [15:0] ha;
        logic [15:0] hb;
    } wave_row_t;

    // Control A, control B, compares, window, high cycles of a and b
    localparam wave_row_t WROWS [11] = '{
        '{8'ha3, 8'h01, 8'h40, 8'h80, 16'h0200, 16'h0082, 16'h0102},
        '{8'hf3, 8'h01, 8'h40, 8'h80, 16'h0200, 16'h017e, 16'h00fe},
        '{8'ha1, 8'h01, 8'h40, 8'h80, 16'h01fe, 16'h0080, 16'h0100},
        '{8'hf1, 8'h01, 8'h40, 8'h80, 16'h01fe, 16'h017e, 16'h00fe},
        '{8'ha1, 8'h09, 8'h80, 8'h20, 16'h0100, 16'h0100, 16'h0040},
        '{8'hf1, 8'h09, 8'h80, 8'h20, 16'h0100, 16'h0000, 16'h00c0},
        '{8'ha3, 8'h09, 8'h7f, 8'h20, 16'h0100, 16'h0100, 16'h0042},
        '{8'h63, 8'h09, 8'h7f, 8'h20, 16'h0100, 16'h0080, 16'h0042},
        '{8'h52, 8'h01, 8'h7f, 8'h20, 16'h0100, 16'h0080, 16'h0080},
        '{8'hb2, 8'h01, 8'h7f, 8'h20, 16'h0100, 16'h0000, 16'h0100},
        '{8'he2, 8'h01, 8'h7f, 8'h20, 16'h0100, 16'h0100, 16'h0000}
    };
    // Control A write value, readback, routing of a and b
    localparam logic [17:0] CROWS [6] = '{{8'hff, 8'hf3, 2'b11}, {8'h40, 8'h40, 2'b10},
        {8'h80, 8'h80, 2'b10}, {8'h10, 8'h10, 2'b01}, {8'h2c, 8'h20, 2'b01},
        {8'h0f, 8'h03, 2'b00}};
    localparam logic [7:0] RST_REGS [7] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_COUNT, OFS_CMP_A,
        OFS_CMP_B, OFS_FLAGS, 8'h30};

    logic clk_i;
    logic rst_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    logic wave_out_a_o;
    logic wave_out_b_o;
    logic pin_override_a_o;
    logic pin_override_b_o;
    logic overflow_flag_o;
    logic match_flag_a_o;
    logic match_flag_b_o;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    timer_wave_control timer_wave_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o), .pin_override_a_o(pin_override_a_o),
        .pin_override_b_o(pin_override_b_o), .overflow_flag_o(overflow_flag_o),
        .match_flag_a_o(match_flag_a_o), .match_flag_b_o(match_flag_b_o));

    always #5 clk_i = ~clk_i;

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Strobe stays up so a following access can start at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        rd_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd

    task automatic idle;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
    endtask : idle

    task automatic meas(input logic [15:0] n, output logic [15:0] ha, output logic [15:0] hb);
        ha = 16'h0000;
        hb = 16'h0000;
        repeat (n) begin
            @(posedge clk_i);
            #1;
            ha = ha + 16'(wave_out_a_o);
            hb = hb + 16'(wave_out_b_o);
        end
    endtask : meas

    initial begin
        logic [7:0] rv;
        logic [15:0] ha;
        logic [15:0] hb;
        clk_i = 1'b0;
        rst_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (RST_REGS[i]) begin
            rd(RST_REGS[i], rv);
            chk("reset_reg", 16'(rv), 16'h0000);
        end
        foreach (CROWS[i]) begin
            wr(OFS_CTRL_A, CROWS[i][17:10]);
            rd(OFS_CTRL_A, rv);
            chk("ctrl_a", 16'(rv), 16'(CROWS[i][9:2]));
            chk("route", 16'({pin_override_a_o, pin_override_b_o}), 16'(CROWS[i][1:0]));
        end
        wr(OFS_CTRL_B, 8'hff);
        rd(OFS_CTRL_B, rv);
        chk("ctrl_b", 16'(rv), 16'h000f);
        wr(8'h30, 8'haa);
        rd(8'h30, rv);
        chk("unmapped", 16'(rv), 16'h0000);
        for (int i = 0; i < 11; i++) begin
            wr(OFS_CTRL_A, WROWS[i].ca);
            wr(OFS_CTRL_B, WROWS[i].cb);
            wr(OFS_CMP_A, WROWS[i].cmpa);
            wr(OFS_CMP_B, WROWS[i].cmpb);
            wr(OFS_COUNT, 8'h00);
            idle();
            repeat (1000) @(posedge clk_i);
            meas(WROWS[i].n, ha, hb);
            chk("wave_a", ha, WROWS[i].ha);
            chk("wave_b", hb, WROWS[i].hb);
        end
        // Force strobes toggle both channels with the clock stopped and raise no flag
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h50);
        wr(OFS_FLAGS, 8'h07);
        wr(OFS_CTRL_B, 8'hc0);
        rd(OFS_FLAGS, rv);
        chk("flags_clear", 16'(rv), 16'h0000);
        chk("force_a", 16'(wave_out_a_o), 16'h0000);
        chk("force_b", 16'(wave_out_b_o), 16'h0001);
        // Overflow at MAX and an immediate compare B update in normal mode
        wr(OFS_CMP_B, 8'hfe);
        wr(OFS_COUNT, 8'hfd);
        wr(OFS_CTRL_B, 8'h01);
        idle();
        repeat (8) @(posedge clk_i);
        chk("overflow", 16'(overflow_flag_o), 16'h0001);
        chk("match_b", 16'(match_flag_b_o), 16'h0001);
        chk("match_a", 16'(match_flag_a_o), 16'h0000);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CTRL_B, rv);
        chk("reset_ctrl_b", 16'(rv), 16'h0000);
        chk("reset_ovf", 16'(overflow_flag_o), 16'h0000);
        chk("reset_match", 16'({match_flag_a_o, match_flag_b_o}), 16'h0000);
        finish_test();
    end
endmodule : testbench

bind timer_wave_control timer_wave_control_sva timer_wave_control_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .wave_out_a_o(wave_out_a_o),
    .wave_out_b_o(wave_out_b_o), .pin_override_a_o(pin_override_a_o),
    .pin_override_b_o(pin_override_b_o), .overflow_flag_o(overflow_flag_o),
    .match_flag_a_o(match_flag_a_o), .match_flag_b_o(match_flag_b_o));
